// >>> verilog/hdlc_rx_pkg.sv
package hdlc_rx_pkg;

  localparam int chan_w   = 5;
  localparam int num_chan = 32;
  localparam int cmd_w    = 10;

  // register indices; the bus byte address is four times the index
  localparam logic [7:0] cmd_idx    = 8'h1a;
  localparam logic [7:0] acc_idx    = 8'h1c;
  localparam logic [7:0] ard_idx    = 8'h1e;
  localparam logic [7:0] fill_idx   = 8'h20;
  localparam logic [7:0] active_idx = 8'h40;

  localparam logic [15:0] cmd_reset  = 16'h0000;
  localparam logic [15:0] acc_reset  = 16'h0000;
  localparam logic [15:0] ard_reset  = 16'h0001;
  localparam logic [7:0]  fill_reset = 8'h00;

  // field positions of the command and access words
  localparam int chan_msb  = 15;
  localparam int chan_lsb  = 11;
  localparam int read_bit  = 10;
  localparam int second_byte_broadcast_match_en_bit  = 9;
  localparam int second_byte_programmed_match_en_bit  = 8;
  localparam int first_byte_broadcast_match_en_bit  = 7;
  localparam int first_byte_programmed_match_en_bit  = 6;
  localparam int crc_bit   = 5;
  localparam int proto_msb = 3;
  localparam int proto_lsb = 2;
  localparam int code_msb  = 1;
  localparam int code_lsb  = 0;

  localparam logic [2:0] hsize_word     = 3'b010;
  localparam logic [7:0] broadcast_byte = 8'hff;

  typedef enum logic [1:0] {
    cmd_abort    = 2'b00,
    cmd_start    = 2'b01,
    cmd_continue = 2'b10,
    cmd_halt     = 2'b11
  } rx_command_type;

  typedef enum logic [1:0] {
    proto_hdlc   = 2'b00,
    proto_fill   = 2'b01,
    proto_nofill = 2'b10,
    proto_rsvd   = 2'b11
  } protocol_type;

  typedef enum logic [1:0] {
    rx_idle = 2'b00,
    rx_run  = 2'b01,
    rx_halt = 2'b11
  } chan_state_type;

  typedef struct packed {
    logic              valid;
    logic [chan_w-1:0] chan;
    logic [7:0]        data;
    logic              sof;
    logic              eof;
    logic              crc;
  } rx_byte_type;

  typedef struct packed {
    logic              valid;
    logic [chan_w-1:0] chan;
    logic [15:0]       data;
    logic [1:0]        cnt;
    logic              sof;
    logic              eof;
    logic              init_desc;
  } rx_word_type;

  typedef struct packed {
    logic              cmd_valid;
    logic [chan_w-1:0] cmd_chan;
    rx_command_type    cmd_code;
    logic              cmd_mid_frame;
    logic              end_valid;
    logic [chan_w-1:0] end_chan;
  } rx_event_type;

endpackage

// >>> verilog/rx_memory.sv
module rx_memory #(
  parameter int width  = 16,
  parameter int depth  = 32,
  parameter int addr_w = 5
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              wr_en,
  input  wire logic [addr_w-1:0] wr_addr,
  input  wire logic [width-1:0]  wr_data,
  input  wire logic [addr_w-1:0] a_addr,
  output logic [width-1:0]       a_data,
  input  wire logic [addr_w-1:0] b_addr,
  output logic [width-1:0]       b_data
);

  logic [width-1:0] mem [depth];

  // storage has no reset; software programs an entry before a channel runs
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      a_data <= '0;
      b_data <= '0;
    end else begin
      a_data <= mem[a_addr];
      b_data <= mem[b_addr];
    end
  end

endmodule

// >>> verilog/hdlc_rx_command_addr_filter.sv
// Our own choice: the AHB-Lite slave port.
module hdlc_rx_command_addr_filter (
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic [31:0]               hrdata,
  output logic                      hresp,
  input  hdlc_rx_pkg::rx_byte_type  rx_in,
  output hdlc_rx_pkg::rx_word_type  rx_out,
  output hdlc_rx_pkg::rx_event_type rx_event
);
  import hdlc_rx_pkg::*;

  logic                wr_pend_reg, wr_pend_next;
  logic [7:0]          wr_idx_reg, wr_idx_next;
  logic [31:0]         hrdata_reg, hrdata_next;
  logic                ready_reg, resp_reg;
  logic [15:0]         cmd_reg, cmd_next, acc_reg, acc_next;
  logic [15:0]         ard_reg, ard_next;
  logic [7:0]          fill_reg, fill_next;
  logic                cmd_ld_reg, cmd_ld_next, ard_ld_reg, ard_ld_next;
  logic                take, mapped, cmd_wr, acc_wr, ard_wr, fill_wr;
  logic [cmd_w-1:0]    cmd_mem_cpu, cmd_mem_rx;
  logic [15:0]         ard_mem_cpu, ard_mem_rx, cmd_view, ard_view;
  logic [num_chan-1:0] active;

  rx_byte_type         s1_reg;
  chan_state_type      st_reg [num_chan], st_next [num_chan];
  logic [num_chan-1:0] frm_reg, frm_next, hold_reg, hold_next;
  logic [num_chan-1:0] ign_reg, ign_next, init_reg, init_next;
  logic [7:0]          held_reg [num_chan], held_next [num_chan];
  rx_word_type         out_reg, out_next;
  rx_event_type        evt_reg, evt_next;

  logic [chan_w-1:0]   ch, cc;
  rx_command_type      code;
  protocol_type        proto;
  logic [7:0]          rxb;
  logic                go, fill_hit, starts, ends, keep, filt, need2, p1, p2;

  function automatic logic byte_ok(input logic [7:0] b, input logic [7:0] prog,
                                   input logic en_prog, input logic en_bc);
    byte_ok = (!en_prog && !en_bc) || (en_prog && b == prog) ||
              (en_bc && b == broadcast_byte);
  endfunction

  // ---------------- bus slave ----------------
  assign take   = hsel && htrans[1] && hready;
  assign mapped = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'b00) && (hsize == hsize_word);

  assign cmd_wr  = wr_pend_reg && (wr_idx_reg == cmd_idx);
  assign acc_wr  = wr_pend_reg && (wr_idx_reg == acc_idx);
  assign ard_wr  = wr_pend_reg && (wr_idx_reg == ard_idx);
  assign fill_wr = wr_pend_reg && (wr_idx_reg == fill_idx);

  // memory read lands one cycle after the launching write; bypass it so a
  // read that follows straight away already sees the fetched entry
  assign cmd_view = cmd_ld_reg ? {cmd_reg[15:read_bit], cmd_mem_cpu} : cmd_reg;
  assign ard_view = ard_ld_reg ? ard_mem_cpu : ard_reg;

  always_comb begin
    wr_pend_next = take && hwrite && mapped;
    wr_idx_next  = haddr[9:2];
    hrdata_next  = hrdata_reg;
    if (take && !hwrite) begin
      hrdata_next = 32'h0;
      if (mapped) begin
        case (haddr[9:2])
          cmd_idx:    hrdata_next = {16'h0, cmd_view};
          acc_idx:    hrdata_next = {16'h0, acc_reg};
          ard_idx:    hrdata_next = {16'h0, ard_view};
          fill_idx:   hrdata_next = {24'h0, fill_reg};
          active_idx: hrdata_next = active;
          default:    hrdata_next = 32'h0;
        endcase
      end
    end
  end

  always_comb begin
    cmd_next    = cmd_reg;
    acc_next    = acc_reg;
    ard_next    = ard_reg;
    fill_next   = fill_reg;
    cmd_ld_next = cmd_wr && hwdata[read_bit];
    ard_ld_next = acc_wr && hwdata[read_bit];
    if (cmd_wr) begin
      cmd_next = hwdata[15:0];
    end else if (cmd_ld_reg) begin
      cmd_next = cmd_view;
    end
    if (acc_wr) begin
      // only channel and direction are kept; the low bits read as zero
      acc_next = {hwdata[15:read_bit], 10'h0};
    end
    if (ard_wr) begin
      ard_next = hwdata[15:0];
    end else if (ard_ld_reg) begin
      ard_next = ard_mem_cpu;
    end
    if (fill_wr) begin
      fill_next = hwdata[7:0];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 8'h00;
      hrdata_reg  <= 32'h0;
      ready_reg   <= 1'b1;
      resp_reg    <= 1'b0;
      cmd_reg     <= cmd_reset;
      acc_reg     <= acc_reset;
      ard_reg     <= ard_reset;
      fill_reg    <= fill_reset;
      cmd_ld_reg  <= 1'b0;
      ard_ld_reg  <= 1'b0;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_idx_reg  <= wr_idx_next;
      hrdata_reg  <= hrdata_next;
      ready_reg   <= 1'b1;
      resp_reg    <= 1'b0;
      cmd_reg     <= cmd_next;
      acc_reg     <= acc_next;
      ard_reg     <= ard_next;
      fill_reg    <= fill_next;
      cmd_ld_reg  <= cmd_ld_next;
      ard_ld_reg  <= ard_ld_next;
    end
  end

  // ---------------- per-channel memories ----------------
  rx_memory #(
    .width  (cmd_w),
    .depth  (num_chan),
    .addr_w (chan_w)
  ) cmd_mem (
    .clk     (mclk),
    .resetn  (resetn),
    .wr_en   (cmd_wr && !hwdata[read_bit]),
    .wr_addr (hwdata[chan_msb:chan_lsb]),
    .wr_data (hwdata[cmd_w-1:0]),
    .a_addr  (hwdata[chan_msb:chan_lsb]),
    .a_data  (cmd_mem_cpu),
    .b_addr  (rx_in.chan),
    .b_data  (cmd_mem_rx)
  );

  rx_memory #(
    .width  (16),
    .depth  (num_chan),
    .addr_w (chan_w)
  ) addr_mem (
    .clk     (mclk),
    .resetn  (resetn),
    .wr_en   (acc_wr && !hwdata[read_bit]),
    .wr_addr (hwdata[chan_msb:chan_lsb]),
    .wr_data (ard_reg),
    .a_addr  (hwdata[chan_msb:chan_lsb]),
    .a_data  (ard_mem_cpu),
    .b_addr  (rx_in.chan),
    .b_data  (ard_mem_rx)
  );

  genvar gi;
  generate
    for (gi = 0; gi < num_chan; gi++) begin : g_active
      assign active[gi] = (st_reg[gi] != rx_idle);
    end
  endgenerate

  // ---------------- receive path ----------------
  // the byte is registered once so that its channel's entries are read out
  // of the memories in step with it
  assign ch       = s1_reg.chan;
  assign rxb      = s1_reg.data;
  assign cc       = hwdata[chan_msb:chan_lsb];
  assign code     = rx_command_type'(hwdata[code_msb:code_lsb]);
  assign proto    = protocol_type'(cmd_mem_rx[proto_msb:proto_lsb]);
  assign go       = s1_reg.valid && (st_reg[ch] != rx_idle) && (proto != proto_rsvd);
  assign fill_hit = (proto == proto_fill) && (rxb == fill_reg);
  assign starts   = !frm_reg[ch] && ((proto == proto_hdlc) ? s1_reg.sof : !fill_hit);
  assign ends     = (proto == proto_fill) ? fill_hit : s1_reg.eof;
  assign keep     = !fill_hit && !(s1_reg.crc && !cmd_mem_rx[crc_bit]);
  // address fields only exist in hdlc framing
  assign filt     = (proto == proto_hdlc) &&
                    (cmd_mem_rx[second_byte_broadcast_match_en_bit:first_byte_programmed_match_en_bit] != 4'h0);
  assign need2    = cmd_mem_rx[second_byte_programmed_match_en_bit] || cmd_mem_rx[second_byte_broadcast_match_en_bit];
  assign p1       = byte_ok(rxb, ard_mem_rx[7:0], cmd_mem_rx[first_byte_programmed_match_en_bit],
                            cmd_mem_rx[first_byte_broadcast_match_en_bit]);
  assign p2       = byte_ok(rxb, ard_mem_rx[15:8], cmd_mem_rx[second_byte_programmed_match_en_bit],
                            cmd_mem_rx[second_byte_broadcast_match_en_bit]);

  always_comb begin
    st_next   = st_reg;
    frm_next  = frm_reg;
    hold_next = hold_reg;
    ign_next  = ign_reg;
    init_next = init_reg;
    held_next = held_reg;
    out_next  = '0;
    evt_next  = '0;

    if (go && (frm_reg[ch] || starts)) begin
      out_next.chan = ch;
      if (starts) begin
        frm_next[ch]  = 1'b1;
        hold_next[ch] = 1'b0;
        ign_next[ch]  = 1'b0;
        if (filt && !p1) begin
          ign_next[ch] = 1'b1;
        end else if (filt && need2) begin
          // first byte waits for the second verdict before anything is written
          held_next[ch] = rxb;
          hold_next[ch] = 1'b1;
        end else begin
          out_next.valid     = 1'b1;
          out_next.data      = {8'h00, rxb};
          out_next.cnt       = 2'd1;
          out_next.sof       = 1'b1;
          out_next.init_desc = init_reg[ch];
          init_next[ch]      = 1'b0;
        end
      end else if (hold_reg[ch]) begin
        hold_next[ch] = 1'b0;
        if (p2) begin
          out_next.valid     = 1'b1;
          out_next.data      = {rxb, held_reg[ch]};
          out_next.cnt       = 2'd2;
          out_next.sof       = 1'b1;
          out_next.init_desc = init_reg[ch];
          init_next[ch]      = 1'b0;
        end else begin
          ign_next[ch] = 1'b1;
        end
      end else if (!ign_reg[ch] && keep) begin
        out_next.valid = 1'b1;
        out_next.data  = {8'h00, rxb};
        out_next.cnt   = 2'd1;
      end

      if (ends) begin
        // a frame still waiting on its second byte never passed the filter
        if (!ign_next[ch] && !hold_next[ch]) begin
          out_next.valid = 1'b1;
          out_next.eof   = 1'b1;
        end
        frm_next[ch]  = 1'b0;
        hold_next[ch] = 1'b0;
        if (st_reg[ch] == rx_halt) begin
          st_next[ch]       = rx_idle;
          evt_next.end_valid = 1'b1;
          evt_next.end_chan  = ch;
        end
      end
    end

    // software wins over a byte of the same channel in the same cycle
    if (cmd_wr && !hwdata[read_bit]) begin
      case (code)
        cmd_abort: begin
          evt_next.cmd_valid     = 1'b1;
          evt_next.cmd_chan      = cc;
          evt_next.cmd_code      = cmd_abort;
          evt_next.cmd_mid_frame = frm_next[cc];
          st_next[cc]   = rx_idle;
          frm_next[cc]  = 1'b0;
          hold_next[cc] = 1'b0;
          ign_next[cc]  = 1'b0;
        end
        cmd_start: begin
          st_next[cc]   = rx_run;
          init_next[cc] = 1'b1;
        end
        cmd_continue: begin
          st_next[cc]   = rx_run;
          init_next[cc] = 1'b0;
        end
        cmd_halt: begin
          if (frm_next[cc]) begin
            st_next[cc] = rx_halt;
          end else begin
            st_next[cc]            = rx_idle;
            evt_next.cmd_valid     = 1'b1;
            evt_next.cmd_chan      = cc;
            evt_next.cmd_code      = cmd_halt;
            evt_next.cmd_mid_frame = 1'b0;
          end
        end
        default: begin
          st_next[cc] = st_reg[cc];
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s1_reg   <= '0;
      frm_reg  <= '0;
      hold_reg <= '0;
      ign_reg  <= '0;
      init_reg <= '0;
      out_reg  <= '0;
      evt_reg  <= '0;
      for (int i = 0; i < num_chan; i++) begin
        st_reg[i]   <= rx_idle;
        held_reg[i] <= 8'h00;
      end
    end else begin
      s1_reg   <= rx_in;
      frm_reg  <= frm_next;
      hold_reg <= hold_next;
      ign_reg  <= ign_next;
      init_reg <= init_next;
      out_reg  <= out_next;
      evt_reg  <= evt_next;
      for (int i = 0; i < num_chan; i++) begin
        st_reg[i]   <= st_next[i];
        held_reg[i] <= held_next[i];
      end
    end
  end

  assign hreadyout = ready_reg;
  assign hrdata    = hrdata_reg;
  assign hresp     = resp_reg;
  assign rx_out    = out_reg;
  assign rx_event  = evt_reg;

endmodule

// >>> dv/rx_line_model.sv
module rx_line_model
  import hdlc_rx_pkg::*;
(
  input wire logic         mclk,
  output hdlc_rx_pkg::rx_byte_type rx_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial rx_in = '0;

  // f = {sof, eof, crc}; one byte a call, then the line carries junk, not the old byte
  task automatic send(input logic [4:0] ch, input logic [7:0] d, input logic [2:0] f);
    @(posedge mclk);
    rx_in <= '{1'b1, ch, d, f[2], f[1], f[0]};
    @(posedge mclk);
    rx_in <= '{1'b0, ~ch, ~d, 1'b0, 1'b0, 1'b0};
  endtask
endmodule

// >>> dv/hdlc_rx_monitor.sv
module hdlc_rx_monitor
  import hdlc_rx_pkg::*;
(
  input wire logic          mclk,
  input wire logic          resetn,
  input wire logic          hsel,
  input wire logic [31:0]   haddr,
  input wire logic [1:0]    htrans,
  input wire logic          hwrite,
  input wire logic [2:0]    hsize,
  input wire logic [31:0]   hwdata,
  input wire logic          hready,
  input wire logic          hreadyout,
  input wire logic [31:0]   hrdata,
  input wire logic          hresp,
  input hdlc_rx_pkg::rx_byte_type  rx_in,
  input hdlc_rx_pkg::rx_word_type  rx_out,
  input hdlc_rx_pkg::rx_event_type rx_event
);
  logic cmd_wr_reg;
  logic cmd_wr_next;

  // marks the data phase of a word write to the command register
  always_comb cmd_wr_next = hsel && htrans[1] && hready && hwrite &&
                            haddr == {22'h0, cmd_idx, 2'b00} && hsize == hsize_word;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) cmd_wr_reg <= 1'b0;
    else cmd_wr_reg <= cmd_wr_next;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_abort_report:
  assert property (cmd_wr_reg && !hwdata[10] && hwdata[1:0] == 2'b00 |=>
    rx_event.cmd_valid && rx_event.cmd_code == cmd_abort &&
    rx_event.cmd_chan == $past(hwdata[15:11])) else $error("abort not reported");
  a_start_quiet:
  assert property (cmd_wr_reg && !hwdata[10] && hwdata[1:0] == 2'b01 |=> !rx_event.cmd_valid)
    else $error("start raised an event");
  a_read_quiet:
  assert property (cmd_wr_reg && hwdata[10] |=> !rx_event.cmd_valid)
    else $error("command read executed");
  a_event_cause:
  assert property (rx_event.cmd_valid |-> $past(cmd_wr_reg)) else $error("event without command");
  a_halt_end:
  assert property (rx_event.end_valid |-> rx_out.valid && rx_out.eof &&
    rx_out.chan == rx_event.end_chan) else $error("halt end not at frame end");
  a_out_latency:
  assert property (rx_out.valid |-> $past(rx_in.valid, 2)) else $error("output without byte");
  a_out_channel:
  assert property (rx_out.valid |-> rx_out.chan == $past(rx_in.chan, 2))
    else $error("output on wrong channel");
  a_pair_start:
  assert property (rx_out.valid && rx_out.cnt == 2'd2 |-> rx_out.sof)
    else $error("byte pair not at frame start");

  c_abort: cover property (rx_event.cmd_valid && rx_event.cmd_mid_frame);
  c_pair:  cover property (rx_out.valid && rx_out.cnt == 2'd2);
  c_end:   cover property (rx_event.end_valid);
endmodule

bind hdlc_rx_command_addr_filter hdlc_rx_monitor hdlc_rx_monitor_i (.mclk, .resetn, .hsel,
  .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .rx_in,
  .rx_out, .rx_event);

// >>> dv/testbench.sv
module testbench;
  import hdlc_rx_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] ca = {22'h0, cmd_idx, 2'b00};
  localparam logic [31:0] aa = {22'h0, acc_idx, 2'b00};
  localparam logic [31:0] da = {22'h0, ard_idx, 2'b00};
  localparam logic [31:0] fa = {22'h0, fill_idx, 2'b00};
  logic         mclk, resetn, hsel, hwrite, hreadyout, hresp, idesc, mid;
  logic [31:0]  haddr, hwdata, hrdata, r;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [7:0]   first;
  rx_byte_type  rx_in;
  rx_word_type  rx_out;
  rx_event_type rx_event;
  int           err_total, checks, sofs, pulses, bytes, eofs, evs, ends;
  logic [7:0]   b1 [5] = '{8'h12, 8'hff, 8'hff, 8'h12, 8'h55};
  logic [7:0]   b2 [5] = '{8'h34, 8'hff, 8'h34, 8'hff, 8'h55};
  int           pb [4] = '{4, 2, 4, 0};

  always #4 mclk = ~mclk;

  hdlc_rx_command_addr_filter hdlc_rx_command_addr_filter_i (.mclk, .resetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .rx_in, .rx_out, .rx_event);
  rx_line_model rx_line_model_i (.mclk, .rx_in);

  always @(posedge mclk) begin
    if (rx_out.valid) begin
      pulses++;
      bytes += rx_out.cnt;
      eofs += rx_out.eof;
      if (rx_out.sof) begin
        sofs++;
        first = rx_out.data[7:0];
        idesc = rx_out.init_desc;
      end
    end
    if (rx_event.cmd_valid) begin
      evs++;
      mid = rx_event.cmd_mid_frame;
    end
    if (rx_event.end_valid) ends++;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (n >= 100) begin
      err_total++;
      results();
    end
  endtask

  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask

  task automatic cmd(input logic [4:0] ch, input logic [3:0] e, input logic c,
                     input logic [1:0] p, input logic [1:0] k);
    xfer(1'b1, ca, {16'h0, ch, 1'b0, e, c, 1'b0, p, k});
  endtask

  // settle covers the two-cycle receive latency plus margin
  task automatic settle;
    repeat (6) @(posedge mclk);
    #1;
  endtask

  task automatic frame(input logic [4:0] ch, input logic [7:0] x, input logic [7:0] y);
    {sofs, pulses, bytes, eofs, evs, ends} = '0;
    rx_line_model_i.send(ch, x, 3'b100);
    rx_line_model_i.send(ch, y, 3'b000);
    rx_line_model_i.send(ch, 8'ha5, 3'b010);
    settle();
  endtask

  function automatic logic pass(input logic [3:0] e, input logic [7:0] x, input logic [7:0] y);
    logic p1;
    logic p2;
    p1 = e[1:0] == 2'b00 || (e[0] && x == 8'h12) || (e[1] && x == 8'hff);
    p2 = e[3:2] == 2'b00 || (e[2] && y == 8'h34) || (e[3] && y == 8'hff);
    return p1 && p2;
  endfunction

  initial begin
    {mclk, resetn, hsel, hwrite, haddr, hwdata, htrans} = '0;
    hsize = hsize_word;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    foreach (pb[i]) begin
      xfer(1'b0, {22'h0, ard_idx + 8'(2 * i), 2'b00} - 32'h8, 32'h0);
      check("reset value", r, i == 1 ? 32'h0001 : 32'h0);
    end
    xfer(1'b0, 32'h3fc, 32'h0);
    check("unmapped", r, 32'h0);
    check("okay response", hresp, 1'b0);
    $display("test reset done");
    xfer(1'b1, da, 32'h3412);
    xfer(1'b1, aa, 32'h1800);
    xfer(1'b1, da, 32'h7856);
    xfer(1'b1, aa, 32'h2000);
    xfer(1'b1, aa, 32'h1c00);
    xfer(1'b0, da, 32'h0);
    check("pair readback", r, 32'h3412);
    xfer(1'b1, aa, 32'h2400);
    xfer(1'b0, da, 32'h0);
    check("pair select", r, 32'h7856);
    cmd(5'd5, 4'h0, 1'b0, proto_hdlc, cmd_start);
    cmd(5'd6, 4'h0, 1'b1, proto_fill, cmd_abort);
    xfer(1'b1, ca, 32'h2c00);
    xfer(1'b0, ca, 32'h0);
    check("command readback", r, 32'h2c01);
    check("command channel", r[9:0], 10'h001);
    $display("test memories done");
    for (int e = 0; e < 16; e++) begin
      for (int k = 0; k < 5; k++) begin
        cmd(5'd3, 4'(e), 1'b0, proto_hdlc, cmd_start);
        frame(5'd3, b1[k], b2[k]);
        check("accepted", sofs, 32'(pass(4'(e), b1[k], b2[k])));
        if (e == 0) check("no filter", sofs, 1);
        if (e == 2) check("first all ones", sofs, 32'(b1[k] == 8'hff));
        if (e == 4) check("second programmed", sofs, 32'(b2[k] == 8'h34));
        if (e == 8) check("second all ones", sofs, 32'(b2[k] == 8'hff));
        if (pass(4'(e), b1[k], b2[k])) begin
          check("first byte", first, b1[k]);
          check("initial descriptor", idesc, 1'b1);
        end
        else check("ignored pulses", pulses, 0);
      end
    end
    cmd(5'd3, 4'h0, 1'b0, proto_hdlc, cmd_continue);
    frame(5'd3, 8'h21, 8'h43);
    check("next descriptor", {sofs[0], idesc}, 2'b10);
    cmd(5'd4, 4'h1, 1'b0, proto_hdlc, cmd_start);
    frame(5'd4, 8'h12, 8'h34);
    check("own pair", sofs, 0);
    frame(5'd4, 8'h56, 8'h34);
    check("own pair", sofs, 1);
    $display("test filter done");
    for (int c = 0; c < 2; c++) begin
      cmd(5'd3, 4'h0, 1'(c), proto_hdlc, cmd_start);
      {sofs, pulses, bytes, eofs} = '0;
      rx_line_model_i.send(5'd3, 8'h01, 3'b100);
      rx_line_model_i.send(5'd3, 8'h02, 3'b000);
      rx_line_model_i.send(5'd3, 8'h03, 3'b001);
      rx_line_model_i.send(5'd3, 8'h04, 3'b011);
      settle();
      check("stored bytes", bytes, 2 + 2 * c);
    end
    xfer(1'b1, fa, 32'h7e);
    for (int p = 0; p < 4; p++) begin
      cmd(5'd3, 4'h0, 1'b0, 2'(p), cmd_start);
      {bytes, eofs} = '0;
      rx_line_model_i.send(5'd3, 8'h7e, 3'b100);
      rx_line_model_i.send(5'd3, 8'h11, 3'b000);
      rx_line_model_i.send(5'd3, 8'h22, 3'b000);
      rx_line_model_i.send(5'd3, 8'h7e, 3'b010);
      settle();
      check("mode bytes", bytes, pb[p]);
      check("mode ends", eofs, 32'(p != 3));
    end
    $display("test modes done");
    cmd(5'd3, 4'h0, 1'b0, proto_hdlc, cmd_start);
    {evs, eofs} = '0;
    rx_line_model_i.send(5'd3, 8'h11, 3'b100);
    cmd(5'd3, 4'h0, 1'b0, proto_hdlc, cmd_abort);
    rx_line_model_i.send(5'd3, 8'h22, 3'b010);
    settle();
    check("abort in frame", {evs[1:0], mid, eofs[0]}, 4'b0110);
    xfer(1'b0, 32'h100, 32'h0);
    check("abort idles", r[3], 1'b0);
    cmd(5'd3, 4'h0, 1'b0, proto_hdlc, cmd_abort);
    settle();
    check("abort idle", {evs[1:0], mid}, 3'b100);
    cmd(5'd3, 4'h0, 1'b0, proto_hdlc, cmd_start);
    {evs, eofs, ends} = '0;
    rx_line_model_i.send(5'd3, 8'h11, 3'b100);
    cmd(5'd3, 4'h0, 1'b0, proto_hdlc, cmd_halt);
    rx_line_model_i.send(5'd3, 8'h22, 3'b010);
    settle();
    check("halt after frame", {evs[1:0], eofs[1:0], ends[1:0]}, 6'b000101);
    frame(5'd3, 8'h31, 8'h32);
    check("halted", pulses, 0);
    $display("test commands done");
    results();
  end
endmodule
